// *** common/ucac_defs.vh ***
/*
  constants for the usb clock and address control register bank:
  byte offsets, field positions, reset values and the write mask.
  assumes a 32-bit classic wishbone bus with byte addresses.
*/
`ifndef UCAC_DEFS_VH
`define UCAC_DEFS_VH

// byte offsets of the two registers
`define UCAC_OFS_CLOCK_CONTROL   4'h0
`define UCAC_OFS_ADDRESS_WAKE    4'h4

// usb_clock_control field positions
`define UCAC_CC_SYSTEM_CLOCK_SELECT_BIT       6
`define UCAC_CC_SECOND_SUSPEND_OPTION_BIT        4
`define UCAC_CC_CLKGATE_BIT      3
`define UCAC_CC_EPSEL_MSB        2
`define UCAC_CC_EPSEL_LSB        0
`define UCAC_CC_WRITE_MASK       8'h5f

// device_address_wake field positions
`define UCAC_AW_ADDR_MSB         7
`define UCAC_AW_ADDR_LSB         1
`define UCAC_AW_WAKE_BIT         0

// reset values
`define UCAC_CC_RESET            8'h00
`define UCAC_AW_RESET            8'h00
`define UCAC_ADDR_RESET          7'h00

// endpoint selector
`define UCAC_EP_COUNT            6
`define UCAC_EP_SEL_W            3

`endif

// *** logic/ucac_epsel.v ***
/*
  registered decode of the endpoint buffer selector into one-hot
  buffer enables plus a valid flag.
  assumes the selector comes from a register on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ucac_defs.vh"

module ucac_epsel #(
  parameter EP_COUNT = `UCAC_EP_COUNT
) (
  input  wire                        clk_i,
  input  wire                        rst_i,
  input  wire [`UCAC_EP_SEL_W-1:0]   code_i,
  output reg  [EP_COUNT-1:0]         onehot_o,
  output reg                         valid_o
);

  wire [EP_COUNT-1:0] hit;

  // one compare per endpoint; codes past the last endpoint hit nothing
  genvar g;
  generate
    for (g = 0; g < EP_COUNT; g = g + 1) begin : g_ep
      localparam [`UCAC_EP_SEL_W-1:0] EP_CODE = g;
      assign hit[g] = (code_i == EP_CODE);
    end
  endgenerate

  // registered so the enables leave the block straight from flops
  always @(posedge clk_i) begin
    if (rst_i) begin
      onehot_o <= {EP_COUNT{1'b0}};
      valid_o  <= 1'b0;
    end else begin
      onehot_o <= hit;
      valid_o  <= |hit;
    end
  end

endmodule // ucac_epsel
`default_nettype wire

// *** logic/ucac_addr.v ***
/*
  device address holder: software writes, plus loading of the address
  taken from the host's set-address command, at once or deferred.
  assumes all engine strobes are one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ucac_defs.vh"

module ucac_addr (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       sw_we_i,
  input  wire [6:0] sw_addr_i,
  input  wire       auto_i,
  input  wire       set_stb_i,
  input  wire [6:0] set_addr_i,
  input  wire       commit_stb_i,
  output reg  [6:0] addr_o,
  output reg        pending_o
);

  reg [6:0] held_reg;

  // engine load beats a software write in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      addr_o    <= `UCAC_ADDR_RESET;
      held_reg  <= `UCAC_ADDR_RESET;
      pending_o <= 1'b0;
    end else if (set_stb_i && auto_i) begin
      addr_o    <= set_addr_i;
      pending_o <= 1'b0;
    end else if (set_stb_i) begin
      held_reg  <= set_addr_i;
      pending_o <= 1'b1;
    end else if (commit_stb_i && pending_o) begin
      addr_o    <= held_reg;
      pending_o <= 1'b0;
    end else if (sw_we_i) begin
      addr_o    <= sw_addr_i;
    end
  end

endmodule // ucac_addr
`default_nettype wire

// *** logic/ucac_top.v ***
/*
  usb clock and address control register bank behind a classic
  wishbone slave: clock select, suspend option, usb clock gate,
  endpoint buffer selector, device address and remote wake enable.
  assumes the serial interface engine and the bus share clk_i (40 MHz).
*/
`timescale 1ns/1ps
`default_nettype none
`include "ucac_defs.vh"

module ucac_top (
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // serial interface engine side
  input  wire        address_auto_update_i,
  input  wire        set_address_stb_i,
  input  wire [6:0]  set_address_value_i,
  input  wire        status_stage_done_i,
  // control outputs
  output reg         system_clock_6mhz_o,
  output reg         bandgap_off_o,
  output reg         usb_clock_run_o,
  output wire [5:0]  endpoint_buffer_enable_o,
  output wire        endpoint_buffer_valid_o,
  output wire [6:0]  device_address_field_o,
  output wire        address_pending_o,
  output reg         remote_wake_enable_o
);

  reg  [7:0] usb_clock_control_reg;
  wire       req;
  wire       wr_lane0;
  wire       hit_cc;
  wire       hit_aw;
  reg  [7:0] read_byte;

  // a request is taken on the edge that raises ack
  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_lane0 = req & wb_we_i & wb_sel_i[0];
  assign hit_cc   = (wb_adr_i == `UCAC_OFS_CLOCK_CONTROL);
  assign hit_aw   = (wb_adr_i == `UCAC_OFS_ADDRESS_WAKE);

  // ack for one cycle per request; unmapped addresses ack too, reading zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= {24'h00_0000, read_byte};
      end
    end
  end

  // read mux; the address byte shows the live address including engine loads
  always @* begin
    read_byte = 8'h00;
    if (hit_cc) begin
      read_byte = usb_clock_control_reg & `UCAC_CC_WRITE_MASK;
    end else if (hit_aw) begin
      read_byte = {device_address_field_o, remote_wake_enable_o};
    end
  end

  // clock control register; write mask drops the two unimplemented bits
  always @(posedge clk_i) begin
    if (rst_i) begin
      usb_clock_control_reg <= `UCAC_CC_RESET;
    end else if (wr_lane0 && hit_cc) begin
      usb_clock_control_reg <= wb_dat_i[7:0] & `UCAC_CC_WRITE_MASK;
    end
  end

  // control outputs mirror the register one cycle later, each from a flop
  always @(posedge clk_i) begin
    if (rst_i) begin
      system_clock_6mhz_o <= 1'b0;
      bandgap_off_o       <= 1'b0;
      usb_clock_run_o     <= 1'b0;
    end else begin
      system_clock_6mhz_o <= usb_clock_control_reg[`UCAC_CC_SYSTEM_CLOCK_SELECT_BIT];
      bandgap_off_o       <= usb_clock_control_reg[`UCAC_CC_SECOND_SUSPEND_OPTION_BIT];
      usb_clock_run_o     <= usb_clock_control_reg[`UCAC_CC_CLKGATE_BIT];
    end
  end

  // remote wake enable; engine address loads leave it untouched
  always @(posedge clk_i) begin
    if (rst_i) begin
      remote_wake_enable_o <= 1'b0;
    end else if (wr_lane0 && hit_aw) begin
      remote_wake_enable_o <= wb_dat_i[`UCAC_AW_WAKE_BIT];
    end
  end

  // codes 110 and 111 are not guarded in hardware; they simply select nothing
  ucac_epsel #(
    .EP_COUNT (`UCAC_EP_COUNT)
  ) u_epsel (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .code_i   (usb_clock_control_reg[`UCAC_CC_EPSEL_MSB:`UCAC_CC_EPSEL_LSB]),
    .onehot_o (endpoint_buffer_enable_o),
    .valid_o  (endpoint_buffer_valid_o)
  );

  ucac_addr u_addr (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .sw_we_i      (wr_lane0 & hit_aw),
    .sw_addr_i    (wb_dat_i[`UCAC_AW_ADDR_MSB:`UCAC_AW_ADDR_LSB]),
    .auto_i       (address_auto_update_i),
    .set_stb_i    (set_address_stb_i),
    .set_addr_i   (set_address_value_i),
    .commit_stb_i (status_stage_done_i),
    .addr_o       (device_address_field_o),
    .pending_o    (address_pending_o)
  );

endmodule // ucac_top
`default_nettype wire

// *** tb/ucac_properties.sv ***
/* ucac_top port checker.
   assumes one clock and sync reset rst_i. */
`timescale 1ns/1ps
`default_nettype none
module ucac_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        address_auto_update_i,
  input wire logic        set_address_stb_i,
  input wire logic [6:0]  set_address_value_i,
  input wire logic        system_clock_6mhz_o,
  input wire logic        bandgap_off_o,
  input wire logic        usb_clock_run_o,
  input wire logic [5:0]  endpoint_buffer_enable_o,
  input wire logic        endpoint_buffer_valid_o,
  input wire logic [6:0]  device_address_field_o,
  input wire logic        address_pending_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request the slave takes at this edge
  sequence take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // outputs trail the register by one cycle, hence the extra ##1
  sequence ctrl_wr_s;
    take_s ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h0);
  endsequence
  chk_ack_answer: assert property (take_s |=> wb_ack_o)
    else $error("no ack after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_clock_sel: assert property (ctrl_wr_s |=> ##1
    system_clock_6mhz_o == $past(wb_dat_i[6], 2)) else $error("clock select wrong");
  chk_bandgap_opt: assert property (ctrl_wr_s |=> ##1
    bandgap_off_o == $past(wb_dat_i[4], 2)) else $error("suspend option wrong");
  chk_clock_gate: assert property (ctrl_wr_s |=> ##1
    usb_clock_run_o == $past(wb_dat_i[3], 2)) else $error("clock gate wrong");
  chk_ep_decode: assert property (ctrl_wr_s |=> ##1 endpoint_buffer_enable_o ==
    ($past(wb_dat_i[2:0], 2) < 3'h6 ? 6'h01 << $past(wb_dat_i[2:0], 2) : 6'h00))
    else $error("endpoint enable wrong");
  chk_ep_valid: assert property (endpoint_buffer_valid_o ==
    $onehot(endpoint_buffer_enable_o)) else $error("endpoint valid wrong");
  chk_addr_now: assert property (set_address_stb_i && address_auto_update_i |=>
    device_address_field_o == $past(set_address_value_i)) else $error("address not loaded");
  chk_addr_defer: assert property (set_address_stb_i && !address_auto_update_i |=>
    address_pending_o) else $error("address not held");
  chk_unused_zero: assert property (take_s ##0 !wb_we_i && wb_adr_i == 4'h0 |=>
    wb_dat_o[31:8] == 24'h0 && !wb_dat_o[7] && !wb_dat_o[5]) else $error("unused bits set");
endmodule // ucac_properties
bind ucac_top ucac_properties u_chk (.*);
`default_nettype wire

// *** tb/tb_top.sv ***
/* self-checking bench for ucac_top.
   drives the wishbone side and the engine strobes itself. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i, rst_i, cyc, stb, we, ack, auto, sst, done;
  logic [3:0] adr, sel;
  logic [31:0] dat, dout, rd;
  logic [6:0] sval, aout;
  logic [5:0] en;
  logic s6, bg, run, vld, pend, wk;
  logic [7:0] d;
  int n_errors, comparisons, i;
  ucac_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout),
    .wb_ack_o(ack), .address_auto_update_i(auto), .set_address_stb_i(sst),
    .set_address_value_i(sval), .status_stage_done_i(done), .system_clock_6mhz_o(s6),
    .bandgap_off_o(bg), .usb_clock_run_o(run), .endpoint_buffer_enable_o(en),
    .endpoint_buffer_valid_o(vld), .device_address_field_o(aout),
    .address_pending_o(pend), .remote_wake_enable_o(wk));
  // 25 ns period
  initial begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end
  task tally_and_finish;
    $display("compares %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one idle cycle, then one classic cycle; read data taken at the ack edge
  task bus(input logic w, input logic [3:0] a, input logic [7:0] v, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, v}; sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dout;
    cyc <= 0; stb <= 0;
  endtask
  function logic [5:0] ep(input logic [2:0] c);
    return c < 3'h6 ? 6'h01 << c : 6'h00;
  endfunction
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    {rst_i, cyc, stb, we, auto, sst, done} = 7'h40;
    {adr, sel, dat, sval} = 0;
    void'($urandom(32'h6f0d));
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    bus(0, 4'h0, 0, 4'hf); chk(rd, 0);
    bus(0, 4'h4, 0, 4'hf); chk(rd, 0);
    $display("test reset done");
    for (i = 0; i < 16; i++) begin
      d = $urandom;
      d[2:0] = 3'(i % 7);
      bus(1, 4'h0, d, 4'hf); bus(0, 4'h0, 0, 4'hf);
      chk(rd, d & 8'h5f);
      chk(s6, d[6]);
      chk(bg, d[4]);
      chk(run, d[3]);
      chk(en, ep(d[2:0]));
      chk(vld, d[2:0] < 3'h6);
      bus(1, 4'h4, d, 4'hf); bus(0, 4'h4, 0, 4'hf);
      chk(rd, d);
      chk(aout, d[7:1]);
      chk(wk, d[0]);
    end
    $display("test registers done");
    bus(1, 4'h0, 8'hfe, 4'he); bus(0, 4'h0, 0, 4'hf); chk(rd, d & 8'h5f);
    bus(0, 4'h8, 0, 4'hf); chk(rd, 0);
    $display("test refusals done");
    bus(1, 4'h0, 8'h48, 4'hf); bus(0, 4'h0, 0, 4'hf);
    chk(s6, 1);
    bus(1, 4'h0, 8'h40, 4'hf); bus(0, 4'h0, 0, 4'hf);
    chk(run, 0);
    chk(bg, 0);
    $display("test suspend entry done");
    @(posedge clk_i); auto <= 1; sst <= 1; sval <= 7'h2a;
    @(posedge clk_i); sst <= 0;
    @(negedge clk_i); chk(aout, 7'h2a);
    @(posedge clk_i); auto <= 0; sst <= 1; sval <= 7'h55;
    @(posedge clk_i); sst <= 0;
    @(negedge clk_i); chk(pend, 1); chk(aout, 7'h2a);
    @(posedge clk_i); done <= 1;
    @(posedge clk_i); done <= 0;
    @(negedge clk_i); chk(aout, 7'h55); chk(pend, 0);
    $display("test engine done");
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
